// ==== acc_id_defines.svh ====
// Constants for the accessory identification block: APB map, field
// positions, reset values, ID converter codes and timing in milliseconds.
// Assumes the crystal clock arrives as a one-mclk pulse per RTC cycle.
// Functional notes
// - Attach moves state machine from standby to active
// - Flow end sets device type and attach flag
// - Unidentified accessory sets unknown-attach flag instead
// - VBUS above high threshold, debounced, sets sense
// - VBUS below low threshold clears sense immediately
// - Debounce select gives 0/10/20/30 ms
// - Threshold selects 3-bit, default code 011
// - Over-voltage during attach raises flag after debounce
// - Over-voltage debounce 0/2/4/8 RTC cycles
// - ID open bit low while resistor present
// - ID falling starts identify, rising starts detach only while VBUS sense is clear
// - Converter enable set, then done, result, clear
// - Result forced 00000 below 2k, 11111 floating
// - Key code runs stuck check, 1.5 s limit
// - Stuck key release flags recovery, restarts identify
// - Probe waits detect delay (code+1)*100 ms
// - ID present: wait done, A/V cable ends flow
// - Probe enable drives DP, sinks DM, compares DM
// - DM in range 20 ms sets forward short
// - ID open: drive DM; DP range: reverse short
// - ID present at t3 ends probe; then decide
// - Probe spacing 20 ms and 100 ms minimums
// - Detach returns to standby, switches off
`ifndef ACC_ID_DEFINES_SVH
`define ACC_ID_DEFINES_SVH

`define RTC_HZ 32768
`define MS_TO_TICKS(ms) (((ms) * `RTC_HZ + 999) / 1000)
`define VBUS_DB_STEP_MS 10
`define PROBE_SETTLE_MS 20
`define PROBE_WINDOW_MS 100
`define DETECT_STEP_MS 100
`define STUCK_KEY_MS 1500
`define TMR_W 17

// APB map
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_IRQ 12'h004
`define REG_STATUS 12'h008
`define REG_DEVTYPE 12'h00c

// Control fields and reset values
`define CTRL_VDB_LSB 0
`define CTRL_VTH_LSB 2
`define CTRL_VTL_LSB 5
`define CTRL_OVDB_LSB 8
`define CTRL_DLY_LSB 10
`define VDB_RST 2'h0
`define VTH_RST 3'h3
`define VTL_RST 3'h3
`define OVDB_RST 2'h0
`define DLY_RST 4'h4

// Event flags
`define IRQ_W 8
`define IRQ_ATTACH 0
`define IRQ_UNKNOWN 1
`define IRQ_SUPDET 2
`define IRQ_OVP 3
`define IRQ_STUCK 4
`define IRQ_STUCKREL 5
`define IRQ_AVCHG 6
`define IRQ_ADCDONE 7

// Device type bits and result field
`define DEV_W 6
`define DEV_USB 0
`define DEV_CHG 1
`define DEV_REVCHG 2
`define DEV_UART 3
`define DEV_AUDIO 4
`define DEV_AV 5
`define DEV_ADC_LSB 8

// ID converter codes
`define ADC_SHORT 5'h00
`define ADC_FLOAT 5'h1f
`define KEY_MIN 5'h01
`define KEY_MAX 5'h0c
`define ADC_AUDIO 5'h10
`define ADC_UART 5'h14
`define ADC_AV 5'h18

`endif

// ==== acc_id_pkg.sv ====
// Types for the accessory identification block.
// Assumes acc_id_defines.svh supplies the numeric constants.
package acc_id_pkg;
  typedef enum logic [5:0] {
    ID_STANDBY = 6'h01,
    ID_ADC = 6'h02,
    ID_STUCK = 6'h04,
    ID_STUCK_WAIT = 6'h08,
    ID_WAIT_PROBE = 6'h10,
    ID_ATTACHED = 6'h20
  } id_state_type;

  typedef enum logic [5:0] {
    PR_IDLE = 6'h01,
    PR_DELAY = 6'h02,
    PR_WAITID = 6'h04,
    PR_FWD = 6'h08,
    PR_REV = 6'h10,
    PR_DONE = 6'h20
  } probe_state_type;
endpackage : acc_id_pkg

// ==== usb_accessory_identification.sv ====
// Accessory identification: ID flow, VBUS detect, stuck key and
// supply type probe, with an APB register slave.
// Assumes all inputs are synchronous to mclk and rtcTick pulses once per
// crystal period.
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/100ps
`include "acc_id_defines.svh"

module usb_accessory_identification
  import acc_id_pkg::*;
#(
  parameter int STUCK_TICKS = `MS_TO_TICKS(`STUCK_KEY_MS),
  parameter int DETECT_STEP_TICKS = `MS_TO_TICKS(`DETECT_STEP_MS),
  parameter int SETTLE_TICKS = `MS_TO_TICKS(`PROBE_SETTLE_MS),
  parameter int WINDOW_TICKS = `MS_TO_TICKS(`PROBE_WINDOW_MS),
  parameter int VDB_STEP_TICKS = `MS_TO_TICKS(`VBUS_DB_STEP_MS)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // APB slave
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Crystal timebase
  input wire logic rtcTick,
  // ID line comparator and converter
  input wire logic idLineOpen,
  input wire logic idBelow2k,
  input wire logic adcDone,
  input wire logic [4:0] adcData,
  input wire logic keyHeld,
  output logic adcEnable,
  // VBUS comparators and threshold selects
  input wire logic vbusAboveHigh,
  input wire logic vbusBelowLow,
  input wire logic vbusOverVolt,
  output logic [2:0] vbusHighThreshSel,
  output logic [2:0] vbusLowThreshSel,
  // Supply type probe
  input wire logic dmInRange,
  input wire logic dpInRange,
  output logic supplyProbeEnable,
  output logic probeSrcDp,
  output logic probeSinkDm,
  output logic probeSrcDm,
  // Mode
  output logic activeMode
);

  // Registers
  id_state_type idState, idStateNext;
  probe_state_type prState, prStateNext;
  logic [1:0] vdbSelReg, ovdbSelReg;
  logic [3:0] dlySelReg;
  logic [`IRQ_W-1:0] irqReg;
  logic [`DEV_W-1:0] devTypeReg;
  logic [4:0] adcResultReg;
  logic idOpenReg, senseReg, idDoneReg, probeDoneReg, fwdShortReg, revShortReg;
  logic ovDoneReg, idSeenReg;
  logic [`TMR_W-1:0] vdbCntReg, ovCntReg, idTmrReg, prTmrReg, prRunReg;

  // APB decode, one wait state per access
  wire apbAcc = psel & penable;
  wire apbDone = apbAcc & pready;
  wire apbWr = apbDone & pwrite;
  wire selCtrl = paddr == `REG_CTRL;
  wire selIrq = paddr == `REG_IRQ;
  wire selStat = paddr == `REG_STATUS;
  wire selDev = paddr == `REG_DEVTYPE;
  wire mapped = selCtrl | selIrq | selStat | selDev;
  wire [`IRQ_W-1:0] irqClr = (apbWr & selIrq) ? pwdata[`IRQ_W-1:0] : '0;

  // ID edges and detach
  wire idFall = idOpenReg & ~idLineOpen;
  wire idRise = ~idOpenReg & idLineOpen;
  wire inStandby = idState == ID_STANDBY;

  // VBUS debounce, zero code qualifies at once
  wire [`TMR_W-1:0] vdbLimit = `TMR_W'(int'(vdbSelReg) * VDB_STEP_TICKS);
  wire senseSet = vbusAboveHigh & ~senseReg & (vdbCntReg >= vdbLimit);
  wire senseClr = vbusBelowLow & senseReg;
  wire detach = ~inStandby & (idRise | senseClr) & idLineOpen & (~senseReg | senseClr);
  wire attachEvt = inStandby & (idFall | senseSet);

  // Over-voltage debounce: 0, 2, 4 or 8 ticks
  wire [`TMR_W-1:0] ovLimit = (ovdbSelReg == 2'h0) ? '0 : (`TMR_W'(1) << ovdbSelReg);
  wire ovArmed = vbusOverVolt & ~ovDoneReg & (~inStandby | senseReg);
  wire ovFire = ovArmed & (ovCntReg >= ovLimit);

  // Converter result with forced codes
  wire [4:0] adcForced = idBelow2k ? `ADC_SHORT : (idLineOpen ? `ADC_FLOAT : adcData);
  wire isKey = (adcForced >= `KEY_MIN) & (adcForced <= `KEY_MAX);
  wire stuckTimeout = idTmrReg >= `TMR_W'(STUCK_TICKS);

  // Probe timing
  wire [`TMR_W-1:0] dlyLimit = `TMR_W'((int'(dlySelReg) + 1) * DETECT_STEP_TICKS);
  wire pastT2 = prTmrReg >= `TMR_W'(SETTLE_TICKS);
  wire runFull = prRunReg >= `TMR_W'(SETTLE_TICKS);
  wire windowEnd = prTmrReg >= `TMR_W'(WINDOW_TICKS);
  wire probeAbort = senseClr | detach;
  wire avFinish = prState == PR_WAITID & idDoneReg & adcResultReg == `ADC_AV;
  wire fwdHit = prState == PR_FWD & runFull;
  wire revHit = prState == PR_REV & runFull;
  wire probeEnd = (prState == PR_FWD & ((fwdHit & ~idLineOpen) | (~fwdHit & windowEnd)))
    | (prState == PR_REV & (revHit | windowEnd));
  wire probeBusy = senseReg & ~probeDoneReg;

  // Accessory decision from ID and VBUS results
  logic [`DEV_W-1:0] devDecide;
  always_comb begin
    devDecide = '0;
    if (adcResultReg == `ADC_AV) begin
      devDecide[`DEV_AV] = 1'b1;
    end else if (fwdShortReg & revShortReg) begin
      devDecide[`DEV_REVCHG] = 1'b1;
    end else if (fwdShortReg) begin
      devDecide[`DEV_CHG] = 1'b1;
    end else if (adcResultReg == `ADC_FLOAT & senseReg) begin
      devDecide[`DEV_USB] = 1'b1;
    end else if (adcResultReg == `ADC_UART) begin
      devDecide[`DEV_UART] = 1'b1;
    end else if (adcResultReg == `ADC_AUDIO) begin
      devDecide[`DEV_AUDIO] = 1'b1;
    end
  end
  wire decideNow = idState == ID_WAIT_PROBE & ~probeBusy & ~avFinish;
  wire unknownNow = decideNow & (devDecide == '0);

  // Identification state transitions
  always_comb begin
    idStateNext = idState;
    case (idState)
      ID_STANDBY: begin
        if (attachEvt) begin
          idStateNext = idLineOpen ? ID_WAIT_PROBE : ID_ADC;
        end
      end
      ID_ADC: begin
        if (adcDone) begin
          idStateNext = isKey ? ID_STUCK : ID_WAIT_PROBE;
        end
      end
      ID_STUCK: begin
        if (~keyHeld) begin
          idStateNext = ID_ADC;
        end else if (stuckTimeout) begin
          idStateNext = ID_STUCK_WAIT;
        end
      end
      ID_STUCK_WAIT: begin
        if (~keyHeld) begin
          idStateNext = ID_ADC;
        end
      end
      ID_WAIT_PROBE: begin
        if (decideNow | avFinish) begin
          idStateNext = ID_ATTACHED;
        end
      end
      ID_ATTACHED: idStateNext = ID_ATTACHED;
      default: idStateNext = ID_STANDBY;
    endcase
    if (detach) begin
      idStateNext = ID_STANDBY;
    end
  end

  // Probe state transitions
  always_comb begin
    prStateNext = prState;
    case (prState)
      PR_IDLE: begin
        if (senseSet) begin
          prStateNext = PR_DELAY;
        end
      end
      PR_DELAY: begin
        if (prTmrReg >= dlyLimit) begin
          prStateNext = (idSeenReg | ~idLineOpen) ? PR_WAITID : PR_FWD;
        end
      end
      PR_WAITID: begin
        if (idDoneReg) begin
          prStateNext = avFinish ? PR_DONE : PR_FWD;
        end
      end
      PR_FWD: begin
        if (probeEnd) begin
          prStateNext = PR_DONE;
        end else if (fwdHit) begin
          prStateNext = PR_REV;
        end
      end
      PR_REV: begin
        if (probeEnd) begin
          prStateNext = PR_DONE;
        end
      end
      PR_DONE: prStateNext = PR_DONE;
      default: prStateNext = PR_IDLE;
    endcase
    if (probeAbort) begin
      prStateNext = PR_IDLE;
    end
  end

  // Event sources, set wins over software clear
  logic [`IRQ_W-1:0] irqSet;
  always_comb begin
    irqSet = '0;
    irqSet[`IRQ_ATTACH] = (decideNow & ~unknownNow) | avFinish;
    irqSet[`IRQ_UNKNOWN] = unknownNow;
    irqSet[`IRQ_SUPDET] = senseSet | senseClr;
    irqSet[`IRQ_OVP] = ovFire;
    irqSet[`IRQ_STUCK] = idState == ID_STUCK & keyHeld & stuckTimeout;
    irqSet[`IRQ_STUCKREL] = idState == ID_STUCK_WAIT & ~keyHeld;
    irqSet[`IRQ_AVCHG] = avFinish;
    irqSet[`IRQ_ADCDONE] = idState == ID_ADC & adcDone;
  end

  // Read data selection
  wire [31:0] rdCtrl = {18'h0, dlySelReg, ovdbSelReg, vbusLowThreshSel, vbusHighThreshSel, vdbSelReg};
  wire [31:0] rdStat = {24'h0, adcEnable, activeMode, revShortReg, fwdShortReg,
    probeDoneReg, idDoneReg, idOpenReg, senseReg};
  wire [31:0] rdDev = {19'h0, adcResultReg, 2'h0, devTypeReg};
  wire [31:0] rdMux = selCtrl ? rdCtrl : selIrq ? {24'h0, irqReg} : selStat ? rdStat : selDev ? rdDev : '0;

  // APB handshake and control register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
      vdbSelReg <= `VDB_RST;
      vbusHighThreshSel <= `VTH_RST;
      vbusLowThreshSel <= `VTL_RST;
      ovdbSelReg <= `OVDB_RST;
      dlySelReg <= `DLY_RST;
    end else begin
      pready <= apbAcc & ~pready;
      pslverr <= apbAcc & ~pready & ~mapped;
      prdata <= (apbAcc & ~pready & ~pwrite) ? rdMux : prdata;
      if (apbWr & selCtrl) begin
        vdbSelReg <= pwdata[`CTRL_VDB_LSB +: 2];
        vbusHighThreshSel <= pwdata[`CTRL_VTH_LSB +: 3];
        vbusLowThreshSel <= pwdata[`CTRL_VTL_LSB +: 3];
        ovdbSelReg <= pwdata[`CTRL_OVDB_LSB +: 2];
        dlySelReg <= pwdata[`CTRL_DLY_LSB +: 4];
      end
    end
  end

  // VBUS sense, over-voltage and event flags; counters move on RTC ticks only
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      irqReg <= '0;
      senseReg <= 1'b0;
      idOpenReg <= 1'b1;
      vdbCntReg <= '0;
      ovCntReg <= '0;
      ovDoneReg <= 1'b0;
    end else begin
      irqReg <= (irqReg & ~irqClr) | irqSet;
      idOpenReg <= idLineOpen;
      senseReg <= senseSet | (senseReg & ~senseClr);
      if (~vbusAboveHigh | senseReg) begin
        vdbCntReg <= '0;
      end else if (rtcTick & ~senseSet) begin
        vdbCntReg <= vdbCntReg + `TMR_W'(1);
      end
      ovDoneReg <= vbusOverVolt & (ovDoneReg | ovFire);
      ovCntReg <= ~ovArmed ? '0 : ovCntReg + `TMR_W'(rtcTick);
    end
  end

  // Identification flow datapath
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idState <= ID_STANDBY;
      adcEnable <= 1'b0;
      adcResultReg <= '0;
      idDoneReg <= 1'b0;
      devTypeReg <= '0;
      idTmrReg <= '0;
      activeMode <= 1'b0;
    end else begin
      idState <= idStateNext;
      activeMode <= idStateNext != ID_STANDBY;
      adcEnable <= idStateNext == ID_ADC & ~(idState == ID_ADC & adcDone);
      idTmrReg <= (idState == ID_STUCK) ? idTmrReg + `TMR_W'(rtcTick) : '0;
      if (idState == ID_ADC & adcDone) begin
        adcResultReg <= adcForced;
      end else if (attachEvt & idLineOpen) begin
        adcResultReg <= `ADC_FLOAT;
      end
      if (detach | attachEvt) begin
        idDoneReg <= attachEvt & idLineOpen;
      end else if (idState == ID_ADC & adcDone & ~isKey) begin
        idDoneReg <= 1'b1;
      end
      if (detach | attachEvt) begin
        devTypeReg <= '0;
      end else if (avFinish) begin
        devTypeReg <= `DEV_W'(1) << `DEV_AV;
      end else if (decideNow) begin
        devTypeReg <= devDecide;
      end
    end
  end

  // Probe datapath: switches, timers and short flags
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prState <= PR_IDLE;
      prTmrReg <= '0;
      prRunReg <= '0;
      idSeenReg <= 1'b0;
      fwdShortReg <= 1'b0;
      revShortReg <= 1'b0;
      probeDoneReg <= 1'b0;
      supplyProbeEnable <= 1'b0;
      probeSrcDp <= 1'b0;
      probeSinkDm <= 1'b0;
      probeSrcDm <= 1'b0;
    end else begin
      prState <= prStateNext;
      // Timer restarts at t1 and at t3
      if (prStateNext != prState) begin
        prTmrReg <= '0;
        prRunReg <= '0;
      end else begin
        prTmrReg <= prTmrReg + `TMR_W'(rtcTick);
        if (prState == PR_FWD) begin
          prRunReg <= (pastT2 & dmInRange) ? prRunReg + `TMR_W'(rtcTick) : '0;
        end else if (prState == PR_REV) begin
          prRunReg <= dpInRange ? prRunReg + `TMR_W'(rtcTick) : '0;
        end
      end
      idSeenReg <= (prState == PR_DELAY) & (idSeenReg | ~idLineOpen);
      if (probeAbort | (prState == PR_IDLE & senseSet)) begin
        fwdShortReg <= 1'b0;
        revShortReg <= 1'b0;
        probeDoneReg <= 1'b0;
      end else begin
        fwdShortReg <= fwdShortReg | fwdHit;
        revShortReg <= revShortReg | revHit;
        probeDoneReg <= probeDoneReg | probeEnd | avFinish;
      end
      // Switch drive follows the next state so it changes with the step
      supplyProbeEnable <= prStateNext == PR_FWD | prStateNext == PR_REV;
      probeSrcDp <= prStateNext == PR_FWD;
      probeSinkDm <= prStateNext == PR_FWD;
      probeSrcDm <= prStateNext == PR_REV;
    end
  end

endmodule : usb_accessory_identification

// ==== acc_id_chk_sva.sv ====
// Port checker for the accessory identification block.
// Assumes rtcTick is a one-mclk pulse.
`timescale 1ns/100ps
module acc_id_chk #(
  parameter int SETTLE_TICKS = 3
) (
  // Clock, reset, timebase
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rtcTick,
  // ID side
  input wire logic idLineOpen,
  input wire logic adcDone,
  input wire logic adcEnable,
  input wire logic activeMode,
  // Thresholds and switches
  input wire logic [2:0] vbusHighThreshSel,
  input wire logic [2:0] vbusLowThreshSel,
  input wire logic supplyProbeEnable,
  input wire logic probeSrcDp,
  input wire logic probeSinkDm,
  input wire logic probeSrcDm
);
  int dpTicks_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Ticks with DP driven, to bound the shortest forward phase
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dpTicks_reg <= 0;
    end else if (!probeSrcDp) begin
      dpTicks_reg <= 0;
    end else if (rtcTick) begin
      dpTicks_reg <= dpTicks_reg + 1;
    end
  end
  a_conv_clears: assert property (adcEnable && adcDone |=> !adcEnable)
    else $error("conversion enable stayed up");
  a_conv_holds: assert property (adcEnable && !adcDone && !idLineOpen |=> adcEnable)
    else $error("conversion enable dropped early");
  a_attach_wakes: assert property (!activeMode && $fell(idLineOpen) |-> ##[1:2] (activeMode && adcEnable))
    else $error("attach did not start identify");
  a_probe_pair: assert property ($rose(supplyProbeEnable) |-> probeSrcDp && probeSinkDm && !probeSrcDm)
    else $error("probe switches wrong at start");
  a_rev_alone: assert property (probeSrcDm |-> !probeSrcDp && !probeSinkDm)
    else $error("reverse drive overlaps forward");
  a_fwd_span: assert property ($fell(probeSrcDp) && activeMode |-> dpTicks_reg >= 2 * SETTLE_TICKS - 1)
    else $error("forward phase too short");
  a_detach_quiet: assert property ($fell(activeMode) |-> !adcEnable && !supplyProbeEnable && !probeSrcDm)
    else $error("switches on in standby");
  a_thresh_default: assert property ($rose(rst_b) |-> vbusHighThreshSel == 3'h3 && vbusLowThreshSel == 3'h3)
    else $error("threshold select reset wrong");
endmodule : acc_id_chk

bind usb_accessory_identification acc_id_chk #(.SETTLE_TICKS(SETTLE_TICKS)) i_chk (.mclk, .rst_b, .rtcTick,
  .idLineOpen, .adcDone, .adcEnable, .activeMode, .vbusHighThreshSel, .vbusLowThreshSel, .supplyProbeEnable,
  .probeSrcDp, .probeSinkDm, .probeSrcDm);

// ==== acc_cable_model.sv ====
// Cable model: ID resistor, converter and DP/DM shorts.
// Assumes the bench sets the cable kind between attaches.
`timescale 1ns/100ps
module acc_cable_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Cable kind
  input wire logic idRes,
  input wire logic below,
  input wire logic [4:0] code,
  input wire logic fwd,
  input wire logic rev,
  // Block switches
  input wire logic adcEnable,
  input wire logic probeSrcDp,
  input wire logic probeSinkDm,
  input wire logic probeSrcDm,
  // Answers
  output logic idLineOpen,
  output logic idBelow2k,
  output logic adcDone,
  output logic [4:0] adcData,
  output logic dmInRange,
  output logic dpInRange
);
  logic [1:0] conv_reg;
  // Converter answers two cycles into a request, once
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      conv_reg <= 2'h0;
    end else if (!adcEnable) begin
      conv_reg <= 2'h0;
    end else if (conv_reg != 2'h3) begin
      conv_reg <= conv_reg + 2'h1;
    end
  end
  // Data inverted outside done so a stale code is never taken
  assign adcDone = (conv_reg == 2'h2);
  assign adcData = adcDone ? code : ~code;
  assign idLineOpen = ~idRes;
  assign idBelow2k = idRes & below;
  // In range only while the matching switches are closed
  assign dmInRange = fwd & probeSrcDp & probeSinkDm;
  assign dpInRange = rev & probeSrcDm;
endmodule : acc_cable_model

// ==== usb_accessory_identification_tb.sv ====
// Self-checking bench for the accessory identification block.
// Assumes the cable model answers conversions and probes.
`timescale 1ns/100ps
`include "acc_id_defines.svh"
module usb_accessory_identification_tb;
  localparam int WI = 15;
  logic mclk = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rtcTick = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, qErr, idLineOpen, idBelow2k, adcDone, adcEnable, dmInRange, dpInRange;
  logic keyHeld = 1'h0, vAbove = 1'h0, vBelow = 1'h0, vOver = 1'h0;
  logic idRes = 1'h0, below = 1'h0, fwd = 1'h0, rev = 1'h0;
  logic [4:0] code = 5'h00, adcData;
  logic supplyProbeEnable, probeSrcDp, probeSinkDm, probeSrcDm, activeMode;
  logic [2:0] hiSel, loSel;
  logic [1:0] div = 2'h0;
  int errors = 0, nTests = 0, cyc = 0, m;
  usb_accessory_identification #(.STUCK_TICKS(20), .DETECT_STEP_TICKS(5), .SETTLE_TICKS(3), .WINDOW_TICKS(WI),
    .VDB_STEP_TICKS(4)) i_dut (.mclk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .rtcTick, .idLineOpen, .idBelow2k, .adcDone, .adcData, .keyHeld, .adcEnable,
    .vbusAboveHigh(vAbove), .vbusBelowLow(vBelow), .vbusOverVolt(vOver), .vbusHighThreshSel(hiSel),
    .vbusLowThreshSel(loSel), .dmInRange, .dpInRange, .supplyProbeEnable, .probeSrcDp, .probeSinkDm,
    .probeSrcDm, .activeMode);
  acc_cable_model i_cable (.mclk, .rst_b, .idRes, .below, .code, .fwd, .rev, .adcEnable, .probeSrcDp,
    .probeSinkDm, .probeSrcDm, .idLineOpen, .idBelow2k, .adcDone, .adcData, .dmInRange, .dpInRange);
  always #25 mclk = ~mclk;
  // RTC pulse every fourth cycle keeps timers short; hang guard
  always @(posedge mclk) begin
    div <= div + 2'h1;
    rtcTick <= (div == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", nTests, errors);
    if (errors == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  // One transfer; idle edge after so strobes never toggle twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // Only pready or the bench timeout ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    q = prdata;
    qErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] k, input logic [31:0] e, input string n);
    apb(1'h0, a, 32'h0);
    chk(n, q & k, e);
  endtask : rdc
  task automatic poll(input logic [11:0] a, input logic [31:0] k, input string n);
    int i;
    i = 0;
    do begin
      apb(1'h0, a, 32'h0);
      i++;
    end while ((q & k) !== k && i < 400);
    chk(n, q & k, k);
  endtask : poll
  task automatic tk(input int n);
    repeat (4 * n) @(posedge mclk);
  endtask : tk
  // Ticks until probe enable reaches the level
  task automatic cnt(input logic lvl);
    int i;
    i = 0;
    m = 0;
    while (supplyProbeEnable !== lvl && i < 3000) begin
      @(posedge mclk);
      i++;
      if (rtcTick) m++;
    end
  endtask : cnt
  task automatic t_regs();
    chk("hiSel", hiSel, 3'h3);
    rdc(`REG_CTRL, 32'h3fff, 32'h106c, "ctrl");
    chk("okErr", qErr, 1'h0);
    apb(1'h0, 12'h010, 32'h0);
    chk("holeErr", qErr, 1'h1);
    chk("holeData", q, 32'h0);
    apb(1'h1, `REG_CTRL, 32'h255);
    @(posedge mclk);
    chk("hiNew", hiSel, 3'h5);
    chk("loNew", loSel, 3'h2);
  endtask : t_regs
  // Cable with ID resistor only, then unplugged
  task automatic t_id(input logic [4:0] c, input logic b, input logic [31:0] irq, input logic [31:0] dev);
    code <= c;
    below <= b;
    idRes <= 1'h1;
    poll(`REG_IRQ, irq, "idIrq");
    chk("active", activeMode, 1'h1);
    rdc(`REG_IRQ, 32'h3, irq & 32'h3, "kind");
    rdc(`REG_DEVTYPE, 32'h1f3f, dev, "idType");
    apb(1'h1, `REG_IRQ, 32'hff);
    idRes <= 1'h0;
    tk(1);
    chk("standby", activeMode, 1'h0);
    rdc(`REG_DEVTYPE, 32'h3f, 32'h0, "noType");
  endtask : t_id
  task automatic t_stuck();
    code <= 5'h05;
    below <= 1'h0;
    keyHeld <= 1'h1;
    idRes <= 1'h1;
    tk(10);
    rdc(`REG_IRQ, 32'h10, 32'h0, "early");
    poll(`REG_IRQ, 32'h10, "stuck");
    rdc(`REG_IRQ, 32'h20, 32'h0, "noRel");
    code <= 5'h10;
    keyHeld <= 1'h0;
    poll(`REG_IRQ, 32'h21, "released");
    rdc(`REG_DEVTYPE, 32'h1f3f, 32'h1010, "audio");
    idRes <= 1'h0;
    apb(1'h1, `REG_IRQ, 32'hff);
  endtask : t_stuck
  task automatic t_usb();
    vAbove <= 1'h1;
    tk(1);
    rdc(`REG_STATUS, 32'h1, 32'h0, "early");
    poll(`REG_STATUS, 32'h1, "sense");
    rdc(`REG_IRQ, 32'h4, 32'h4, "detIrq");
    cnt(1'h1);
    chk("delay", m >= 3 && m <= 5, 1'h1);
    cnt(1'h0);
    chk("window", m >= WI - 1 && m <= WI + 1, 1'h1);
    poll(`REG_STATUS, 32'h8, "done");
    rdc(`REG_STATUS, 32'h30, 32'h0, "noShort");
    rdc(`REG_DEVTYPE, 32'h1f3f, 32'h1f01, "usb");
    apb(1'h1, `REG_IRQ, 32'hff);
    vOver <= 1'h1;
    tk(2);
    rdc(`REG_IRQ, 32'h8, 32'h0, "ovEarly");
    tk(4);
    rdc(`REG_IRQ, 32'h8, 32'h8, "ov");
    vOver <= 1'h0;
    apb(1'h1, `REG_IRQ, 32'hff);
    vAbove <= 1'h0;
    vBelow <= 1'h1;
    rdc(`REG_STATUS, 32'h1, 32'h0, "drop");
    rdc(`REG_IRQ, 32'h4, 32'h4, "dropIrq");
    chk("off", activeMode, 1'h0);
  endtask : t_usb
  task automatic t_rev();
    vBelow <= 1'h0;
    fwd <= 1'h1;
    rev <= 1'h1;
    vAbove <= 1'h1;
    poll(`REG_STATUS, 32'h38, "revDone");
    rdc(`REG_DEVTYPE, 32'h4, 32'h4, "revType");
    vAbove <= 1'h0;
    vBelow <= 1'h1;
    tk(1);
    fwd <= 1'h0;
    rev <= 1'h0;
  endtask : t_rev
  task automatic t_av();
    apb(1'h1, `REG_IRQ, 32'hff);
    vBelow <= 1'h0;
    code <= 5'h18;
    idRes <= 1'h1;
    vAbove <= 1'h1;
    poll(`REG_IRQ, 32'h41, "avIrq");
    rdc(`REG_DEVTYPE, 32'h3f, 32'h20, "avType");
  endtask : t_av
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    t_regs();
    t_id(5'h14, 1'h0, 32'h81, 32'h1408);
    t_id(5'h1c, 1'h1, 32'h82, 32'h0000);
    t_stuck();
    t_usb();
    t_rev();
    t_av();
    finish_test();
  end
endmodule : usb_accessory_identification_tb
